// ### verilog/dsasc_top.sv
/*
 * dsasc_top: APB-reached datapath for the double left shift and the
 * set-byte-on-condition group, with memory-destination fault checks.
 * assumes: APB master per AMBA rules; env bits are written by the memory
 * pipeline model through the env register before go.
 */
// The address map and register access over APB were decided locally.
// Contract
// - count-register form takes the count from the count register low byte
// - immediate form takes the count from the immediate byte
// - destination shifts left, source bits enter at bit 0
// - only count bits 4..0 are used
// - counts at or above operand size give undefined result and flags
// - carry gets destination bit at size minus count
// - one-bit shift sets overflow on sign change, else clears it
// - zero count changes nothing
// - register or memory destination, register source, 16 or 32 bits
// - upper destination bits take the bit count positions lower
// - low bits come from source bit index minus count plus size
// - sign, zero, parity follow result; overflow, adjust undefined otherwise
// - set-on-condition writes one when condition holds, else zero
// - greater and not-less-equal share a code: zero clear, sign equals overflow
// - protected-mode store to unwritable segment gives protection fault zero
// - protected-mode null data selector gives protection fault zero
// - stack limit violation gives stack fault, code zero in protected mode
// - page fault during memory access aborts with fault code
// - protected mode alignment fault needs checking on and privilege three
// - virtual-8086 alignment fault needs only checking on
`timescale 1ns/10ps
`include "dsasc_regs.svh"
module dsasc_top
    import dsasc_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic busy
);
    if (ADDR_W < 8) begin : g_addr_chk
        $error("dsasc_top: ADDR_W too small for the map");
    end

    logic [31:0] ctrl_reg;
    logic [31:0] dst_reg;
    logic [31:0] src_reg;
    logic [31:0] cnt_reg;
    logic [31:0] flags_reg;
    logic [31:0] result_reg;
    logic [31:0] env_reg;
    logic [31:0] fault_code_reg;
    logic [31:0] status_reg;
    logic [31:0] prdata_reg;
    dsasc_state_t state_reg;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = val[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // bus decode
    wire logic access = psel && penable;
    wire logic wr = access && pwrite;
    wire logic [11:0] off = 12'(paddr);
    wire logic hit_ctrl = off == `DSASC_CTRL_OFF;
    wire logic hit_dst = off == `DSASC_DST_OFF;
    wire logic hit_src = off == `DSASC_SRC_OFF;
    wire logic hit_cnt = off == `DSASC_CNT_OFF;
    wire logic hit_flags = off == `DSASC_FLAGS_OFF;
    wire logic hit_res = off == `DSASC_RESULT_OFF;
    wire logic hit_stat = off == `DSASC_STATUS_OFF;
    wire logic hit_env = off == `DSASC_ENV_OFF;
    wire logic hit_fcode = off == `DSASC_FAULTCODE_OFF;
    wire logic mapped = hit_ctrl | hit_dst | hit_src | hit_cnt | hit_flags | hit_res |
        hit_stat | hit_env | hit_fcode;
    // writes to the read-only registers are refused too
    wire logic bad = !mapped || (pwrite && (hit_res || hit_stat));
    wire logic exec_now = state_reg == DSASC_EXEC;

    assign pready = 1'b1;
    assign pslverr = access && bad;
    assign prdata = prdata_reg;
    assign busy = exec_now;

    wire logic [31:0] rd_mux = hit_ctrl ? ctrl_reg :
        hit_dst ? dst_reg :
        hit_src ? src_reg :
        hit_cnt ? cnt_reg :
        hit_flags ? flags_reg :
        hit_res ? result_reg :
        hit_stat ? status_reg :
        hit_env ? env_reg :
        hit_fcode ? fault_code_reg : 32'h0;

    // operation fields
    wire logic [1:0] op = ctrl_reg[`DSASC_CTRL_OP_LO +: 2];
    wire logic size32 = ctrl_reg[`DSASC_CTRL_SIZE32];
    // set_byte_on_condition is byte-only; the size bit only matters to the shift
    wire logic mem_dst = ctrl_reg[`DSASC_CTRL_MEMDST];
    wire logic [3:0] cond = ctrl_reg[`DSASC_CTRL_COND_LO +: 4];
    wire logic go = wr && hit_ctrl && pstrb[0] && pwdata[`DSASC_CTRL_GO] && !exec_now;

    // environment from the memory pipeline
    wire logic pmode = env_reg[`DSASC_ENV_PMODE];
    wire logic v86 = env_reg[`DSASC_ENV_V86];
    wire logic ac_en = env_reg[`DSASC_ENV_AC_EN];
    wire logic [1:0] current_privilege_level = env_reg[`DSASC_ENV_CPL_LO +: 2];
    wire logic no_write = env_reg[`DSASC_ENV_NOWRITE];
    wire logic null_sel = env_reg[`DSASC_ENV_NULLSEL];
    wire logic ss_limit = env_reg[`DSASC_ENV_SSLIM];
    wire logic page_miss = env_reg[`DSASC_ENV_PAGEF];
    wire logic unaligned = env_reg[`DSASC_ENV_UNALIGN];

    wire logic [31:0] ex_result;
    wire logic [31:0] ex_flags;
    wire logic ex_writes;

    dsasc_exec #(
        .WIDTH(32)
    ) u_exec (
        .op(op),
        .size32(size32),
        .cond(cond),
        .dst(dst_reg),
        .src(src_reg),
        .count_register_low_byte(cnt_reg[7:0]),
        .immediate_byte(ctrl_reg[23:16]),
        .flags_in(flags_reg),
        .result(ex_result),
        .flags_out(ex_flags),
        .writes_dst(ex_writes)
    );

    // fault priority: protection, stack, page, alignment
    wire logic general_protection_fault = mem_dst && pmode && !v86 &&
        (no_write || null_sel);
    wire logic stack_fault = mem_dst && ss_limit;
    wire logic page_fault = mem_dst && page_miss;
    wire logic align_pm = pmode && !v86 && current_privilege_level == `DSASC_CPL_USER;
    wire logic alignment_check_fault = mem_dst && unaligned && ac_en &&
        (align_pm || v86);
    wire dsasc_fault_t fault_kind = general_protection_fault ? DSASC_FLT_GP :
        stack_fault ? DSASC_FLT_SS :
        page_fault ? DSASC_FLT_PF :
        alignment_check_fault ? DSASC_FLT_AC : DSASC_FLT_NONE;
    // a register destination never faults; a zero-count shift still checks memory
    wire logic faulted = fault_kind != DSASC_FLT_NONE;
    // stack fault carries code zero in protected mode only; real mode has none
    wire logic err_zero = (fault_kind == DSASC_FLT_GP) || (fault_kind == DSASC_FLT_AC) ||
        ((fault_kind == DSASC_FLT_SS) && pmode);

    wire logic commit = exec_now && !faulted;
    wire logic [31:0] status_next = {27'h0, err_zero, fault_kind, 1'b1};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= DSASC_IDLE;
        end else begin
            unique case (state_reg)
                DSASC_IDLE: state_reg <= go ? DSASC_EXEC : DSASC_IDLE;
                DSASC_EXEC: state_reg <= DSASC_IDLE;
                default: state_reg <= DSASC_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= 32'h0;
            src_reg <= 32'h0;
            cnt_reg <= 32'h0;
            env_reg <= 32'h0;
            fault_code_reg <= 32'h0;
            prdata_reg <= 32'h0;
        end else begin
            if (wr && hit_ctrl && !exec_now) begin
                ctrl_reg <= merge(ctrl_reg, pwdata, pstrb) & 32'hfffffffe;
            end
            if (wr && hit_src) begin
                src_reg <= merge(src_reg, pwdata, pstrb);
            end
            if (wr && hit_cnt) begin
                cnt_reg <= merge(cnt_reg, pwdata, pstrb);
            end
            if (wr && hit_env) begin
                env_reg <= merge(env_reg, pwdata, pstrb);
            end
            if (wr && hit_fcode) begin
                fault_code_reg <= merge(fault_code_reg, pwdata, pstrb);
            end
            if (psel && !penable && !pwrite) begin
                prdata_reg <= rd_mux;
            end
        end
    end

    // hardware commit wins over a bus write in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dst_reg <= 32'h0;
            flags_reg <= `DSASC_FLAGS_RST;
            result_reg <= 32'h0;
            status_reg <= 32'h0;
        end else begin
            if (commit) begin
                if (ex_writes) begin
                    dst_reg <= ex_result;
                end
                flags_reg <= ex_flags;
                result_reg <= ex_result;
            end else if (wr && hit_dst) begin
                dst_reg <= merge(dst_reg, pwdata, pstrb);
            end else if (wr && hit_flags) begin
                flags_reg <= merge(flags_reg, pwdata, pstrb);
            end
            if (exec_now) begin
                status_reg <= status_next;
            end else if (go) begin
                status_reg <= 32'h0;
            end
        end
    end
endmodule

// ### verilog/dsasc_regs.svh
/*
 * dsasc_regs.svh: offsets, field positions, reset values and op codes for the
 * double shift / set-on-condition datapath.
 * assumes: included by bare name from the design modules, the checker and the testbench.
 */
`ifndef DSASC_REGS_SVH
`define DSASC_REGS_SVH

// register byte offsets
`define DSASC_CTRL_OFF      12'h000
`define DSASC_DST_OFF       12'h004
`define DSASC_SRC_OFF       12'h008
`define DSASC_CNT_OFF       12'h00c
`define DSASC_FLAGS_OFF     12'h010
`define DSASC_RESULT_OFF    12'h014
`define DSASC_STATUS_OFF    12'h018
`define DSASC_ENV_OFF       12'h01c
`define DSASC_FAULTCODE_OFF 12'h020

// ctrl fields
`define DSASC_CTRL_GO       0
`define DSASC_CTRL_OP_LO    1
`define DSASC_CTRL_SIZE32   3
`define DSASC_CTRL_MEMDST   4
`define DSASC_CTRL_COND_LO  8

// op codes in ctrl[2:1]
`define DSASC_OP_SHL_IMM    2'h0
`define DSASC_OP_SHL_CNT    2'h1
`define DSASC_OP_SET_BYTE_ON_CONDITION      2'h2

// flag positions in the flags register
`define DSASC_CF  0
`define DSASC_PF  2
`define DSASC_AF  4
`define DSASC_ZF  6
`define DSASC_SF  7
`define DSASC_OF  11

// env fields (memory-side conditions reported by the pipeline)
`define DSASC_ENV_PMODE     0
`define DSASC_ENV_V86       1
`define DSASC_ENV_AC_EN     2
`define DSASC_ENV_CPL_LO    3
`define DSASC_ENV_NOWRITE   5
`define DSASC_ENV_NULLSEL   6
`define DSASC_ENV_SSLIM     7
`define DSASC_ENV_PAGEF     8
`define DSASC_ENV_UNALIGN   9

// status fields
`define DSASC_ST_DONE       0
`define DSASC_ST_FAULT_LO   1
`define DSASC_ST_ERRZERO    4

`define DSASC_FLAGS_RST     32'h0000_0002
`define DSASC_CPL_USER      2'h3

`endif

// ### verilog/dsasc_pkg.sv
/*
 * dsasc_pkg: types shared by the datapath modules.
 * assumes: constants come from dsasc_regs.svh.
 */
package dsasc_pkg;
    typedef enum logic [2:0] {
        DSASC_FLT_NONE = 3'h0,
        DSASC_FLT_GP = 3'h1,
        DSASC_FLT_SS = 3'h2,
        DSASC_FLT_PF = 3'h3,
        DSASC_FLT_AC = 3'h4
    } dsasc_fault_t;

    typedef enum logic [1:0] {
        DSASC_IDLE = 2'b01,
        DSASC_EXEC = 2'b10
    } dsasc_state_t;
endpackage

// ### verilog/dsasc_exec.sv
/*
 * dsasc_exec: combinational core of the double left shift and set-on-condition.
 * assumes: operands stable while the caller samples the outputs.
 */
`timescale 1ns/10ps
`include "dsasc_regs.svh"
module dsasc_exec
    import dsasc_pkg::*;
#(
    parameter int WIDTH = 32
) (
    input wire logic [1:0] op,
    input wire logic size32,
    input wire logic [3:0] cond,
    input wire logic [WIDTH-1:0] dst,
    input wire logic [WIDTH-1:0] src,
    input wire logic [7:0] count_register_low_byte,
    input wire logic [7:0] immediate_byte,
    input wire logic [WIDTH-1:0] flags_in,
    output logic [WIDTH-1:0] result,
    output logic [WIDTH-1:0] flags_out,
    output logic writes_dst
);
    // flag positions and the byte select assume one 32-bit word
    if (WIDTH != 32) begin : g_width_chk
        $error("dsasc_exec: WIDTH must be 32");
    end

    function automatic logic cond_true(input logic [3:0] c, input logic [WIDTH-1:0] f);
        logic r;
        r = 1'b0;
        unique case (c[3:1])
            3'h0: r = f[`DSASC_OF];
            3'h1: r = f[`DSASC_CF];
            3'h2: r = f[`DSASC_ZF];
            3'h3: r = f[`DSASC_CF] | f[`DSASC_ZF];
            3'h4: r = f[`DSASC_SF];
            3'h5: r = f[`DSASC_PF];
            3'h6: r = f[`DSASC_SF] ^ f[`DSASC_OF];
            3'h7: r = f[`DSASC_ZF] | (f[`DSASC_SF] ^ f[`DSASC_OF]);
        endcase
        // odd codes negate; code 0xf is greater / not-less-equal alike
        return r ^ c[0];
    endfunction

    wire logic [7:0] raw_count = (op == `DSASC_OP_SHL_CNT) ?
        count_register_low_byte : immediate_byte;
    wire logic [4:0] count = raw_count[4:0];
    wire logic [5:0] size = size32 ? 6'd32 : 6'd16;
    wire logic shift_op = (op == `DSASC_OP_SHL_IMM) || (op == `DSASC_OP_SHL_CNT);
    // 16-bit form: the source sits right below the destination, 32-bit: full width
    wire logic [63:0] joined = size32 ? {dst, src} : {dst[15:0], src[15:0], 32'h0};
    wire logic [63:0] shifted = joined << count;
    wire logic [31:0] res32 = size32 ? shifted[63:32] : {dst[31:16], shifted[63:48]};
    wire logic [15:0] low16 = res32[15:0];
    wire logic msb_new = size32 ? res32[31] : res32[15];
    wire logic msb_old = size32 ? dst[31] : dst[15];
    // last bit out is dst[size-count]; undefined counts just reuse the same path
    wire logic [5:0] out_pos = size - {1'b0, count};
    wire logic carry_out = dst[out_pos[4:0]];
    wire logic zero_res = size32 ? (res32 == 32'h0) : (low16 == 16'h0);
    wire logic par_res = ~^res32[7:0];
    wire logic set_bit = cond_true(cond, flags_in);

    always_comb begin
        result = dst;
        flags_out = flags_in;
        writes_dst = 1'b0;
        if (shift_op && count != 5'h0) begin
            // counts >= size give an undefined but harmless value
            writes_dst = 1'b1;
            result = res32;
            flags_out[`DSASC_CF] = carry_out;
            flags_out[`DSASC_SF] = msb_new;
            flags_out[`DSASC_ZF] = zero_res;
            flags_out[`DSASC_PF] = par_res;
            flags_out[`DSASC_AF] = 1'b0;
            flags_out[`DSASC_OF] = msb_new ^ msb_old;
        end else if (op == `DSASC_OP_SET_BYTE_ON_CONDITION) begin
            writes_dst = 1'b1;
            result = {dst[31:8], 7'h0, set_bit};
        end
    end
endmodule

// ### sim/dsasc_top_asserts.sv
/* dsasc_top_asserts: port checks on the apb side of dsasc_top.
 * assumes: bound to every dsasc_top; zero wait states, one exec cycle per go. */
`timescale 1ns/10ps
`include "dsasc_regs.svh"
module dsasc_chk #(
    parameter int ADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic busy
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable;
    wire go_wr = acc && pwrite && paddr == `DSASC_CTRL_OFF && pwdata[0] && pstrb[0];
    wire ro_wr = acc && pwrite && (paddr == `DSASC_RESULT_OFF || paddr == `DSASC_STATUS_OFF);
    a_ready_high: assert property (pready) else $error("pready low");
    a_err_in_access: assert property (pslverr |-> acc) else $error("stray pslverr");
    a_err_unmapped: assert property (acc && paddr > `DSASC_FAULTCODE_OFF |-> pslverr)
        else $error("unmapped access not refused");
    a_err_ro_write: assert property (ro_wr |-> pslverr) else $error("ro write taken");
    a_mapped_read: assert property (acc && !pwrite && paddr <= `DSASC_FAULTCODE_OFF
        && paddr[1:0] == 2'b00 |-> !pslverr) else $error("mapped read refused");
    a_go_starts: assert property (go_wr && !busy |=> busy) else $error("go ignored");
    a_busy_cause: assert property ($rose(busy) |-> $past(go_wr))
        else $error("busy without go");
    a_busy_single: assert property (busy |=> !busy)
        else $error("busy too long");
    a_rdata_steady: assert property (acc |=> $stable(prdata))
        else $error("read data moved in access");
    c_go: cover property (go_wr ##1 busy);
    c_err: cover property (acc && pslverr);
    c_read: cover property (acc && !pwrite && paddr == `DSASC_STATUS_OFF);
endmodule

bind dsasc_top dsasc_chk #(.ADDR_W(ADDR_W)) u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy));

// ### sim/dsasc_mem_pipe.sv
/* dsasc_mem_pipe: memory pipeline conditions for one scenario kind and the
 * fault it should cause. assumes: tb copies env into the env register. */
`timescale 1ns/10ps
module dsasc_mem_pipe (
    input wire logic [2:0] kind,
    output logic [31:0] env,
    output logic [2:0] fault
);
    always_comb begin
        case (kind)
            3'h0: {env, fault} = {32'h021, 3'h1};
            3'h1: {env, fault} = {32'h041, 3'h1};
            3'h2: {env, fault} = {32'h081, 3'h2};
            3'h3: {env, fault} = {32'h101, 3'h3};
            3'h4: {env, fault} = {32'h21d, 3'h4};
            3'h5: {env, fault} = {32'h215, 3'h0};
            default: {env, fault} = {32'h206, 3'h4};
        endcase
    end
endmodule

// ### sim/dsasc_top_tb.sv
/* dsasc_top_tb: apb driver with expectation queue and a monitor that pops it.
 * assumes: zero wait states; results readable from the first transfer after go. */
`timescale 1ns/10ps
`include "dsasc_regs.svh"
module dsasc_top_tb;
    typedef struct {logic [31:0] d; logic [31:0] m; logic e;} dsasc_exp_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [2:0] kind = 3'h0;
    wire [31:0] prdata;
    wire pready, pslverr, busy;
    wire [31:0] env;
    wire [2:0] flt;
    dsasc_exp_t q[$];
    dsasc_exp_t cur;
    int err_count = 0;
    int cmp_count = 0;
    always #20 pclk = ~pclk;
    dsasc_top #(.ADDR_W(12)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy));
    dsasc_mem_pipe PIPE (.kind(kind), .env(env), .fault(flt));

    // every transfer, write or read, leaves one note; writes only check pslverr
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
            input logic [31:0] m, input logic e);
        q.push_back('{d & m, m, e});
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hf;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic do_op(input logic [31:0] ctrl, d, s, c, f, e, ed, md, ef, mf, es);
        apb(1'b1, `DSASC_DST_OFF, d, 32'h0, 1'b0);
        apb(1'b1, `DSASC_SRC_OFF, s, 32'h0, 1'b0);
        apb(1'b1, `DSASC_CNT_OFF, c, 32'h0, 1'b0);
        apb(1'b1, `DSASC_FLAGS_OFF, f, 32'h0, 1'b0);
        apb(1'b1, `DSASC_ENV_OFF, e, 32'h0, 1'b0);
        apb(1'b1, `DSASC_CTRL_OFF, ctrl | 32'h1, 32'h0, 1'b0);
        apb(1'b0, `DSASC_DST_OFF, ed, md, 1'b0);
        apb(1'b0, `DSASC_FLAGS_OFF, ef, mf, 1'b0);
        apb(1'b0, `DSASC_STATUS_OFF, es, 32'h1f, 1'b0);
    endtask

    // the unused count source gets the inverse, so a wrong pick shows
    task automatic shift_case(input logic op, input logic s32, input logic [7:0] cnt);
        logic [31:0] d, s, f, r, ef, mf, md;
        logic [63:0] w;
        int n;
        d = $urandom;
        s = $urandom;
        f = ($urandom & 32'h8d5) | 32'h2;
        n = cnt[4:0];
        r = d;
        ef = f;
        mf = 32'h8d7;
        md = 32'hffff_ffff;
        if (n != 0 && s32) begin
            w = {d, s} << n;
            r = w[63:32];
            ef[0] = d[32-n];
            ef[6] = (r == 32'h0);
            ef[7] = r[31];
            ef[11] = r[31] ^ d[31];
        end else if (n != 0) begin
            w = {32'h0, d[15:0], s[15:0]} << n;
            r = {d[31:16], w[31:16]};
            ef[0] = d[16-n];
            ef[6] = (r[15:0] == 16'h0);
            ef[7] = r[15];
            ef[11] = r[15] ^ d[15];
        end
        if (n != 0) begin
            ef[2] = ~^r[7:0];
            mf = (n == 1) ? 32'h8c7 : 32'h0c7;
        end
        if (n >= (s32 ? 32 : 16)) begin
            md = 32'h0;
            mf = 32'h0;
        end
        do_op({8'h0, op ? ~cnt : cnt, 12'h0, s32, 1'b0, op, 1'b0}, d, s,
            {24'h0, op ? cnt : ~cnt},
            f, 32'h0, r, md, ef, mf, 32'h1);
    endtask

    function automatic logic cond_ok(input logic [3:0] c, input logic [31:0] f);
        logic r;
        case (c[3:1])
            3'h0: r = f[11];
            3'h1: r = f[0];
            3'h2: r = f[6];
            3'h3: r = f[0] | f[6];
            3'h4: r = f[7];
            3'h5: r = f[2];
            3'h6: r = f[7] ^ f[11];
            default: r = f[6] | (f[7] ^ f[11]);
        endcase
        return r ^ c[0];
    endfunction

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    always @(posedge pclk) begin
        if (psel && penable && pready && q.size() > 0) begin
            cur = q.pop_front();
            cmp_count++;
            if (((prdata & cur.m) !== cur.d) || (pslverr !== cur.e)) begin
                err_count++;
                $display("BAD t=%0t got %h/%h exp %h/%h", $time, prdata & cur.m, pslverr,
                    cur.d, cur.e);
            end
        end
    end

    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        wrap_up();
    end

    initial begin
        logic [31:0] d, f, r;
        logic [7:0] tbl [6] = '{8'h00, 8'h01, 8'h20, 8'he1, 8'h0f, 8'h1f};
        void'($urandom(32'h4505c983));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `DSASC_FLAGS_OFF, `DSASC_FLAGS_RST, 32'hffff_ffff, 1'b0);
        apb(1'b0, `DSASC_DST_OFF, 32'h0, 32'hffff_ffff, 1'b0);
        for (int i = 0; i < 6; i++)
            shift_case(i[0], i != 4, tbl[i]);
        repeat (12)
            shift_case($urandom, $urandom, $urandom);
        for (int c = 0; c < 16; c++) begin
            d = $urandom;
            f = $urandom & 32'h8c5;
            do_op({20'h0, c[3:0], 8'h4}, d, 32'h0, 32'h0, f, 32'h0,
                {d[31:8], 7'h0, cond_ok(c[3:0], f)}, 32'hffff_ffff, f, 32'h8d7, 32'h1);
        end
        for (int k = 0; k < 7; k++) begin
            kind <= k[2:0];
            d = $urandom;
            @(posedge pclk);
            // a clean one-bit shift must show its flags, a faulted one none
            r = d << 1;
            f = (flt == 3'h0) ? {20'h0, r[31] ^ d[31], 3'h0, r[31], r == 32'h0, 3'h0, ~^r[7:0],
                1'b1, d[31]} : 32'h2;
            do_op(32'h1a, d, 32'h0, 32'h1, 32'h2, env, (flt == 3'h0) ? r : d,
                32'hffff_ffff, f, 32'h8c5,
                {27'h0, flt != 3'h0 && flt != 3'h3, flt, 1'b1});
        end
        apb(1'b1, `DSASC_RESULT_OFF, 32'h0, 32'h0, 1'b1);
        apb(1'b1, `DSASC_STATUS_OFF, 32'h0, 32'h0, 1'b1);
        apb(1'b0, 12'h0fc, 32'h0, 32'h0, 1'b1);
        repeat (2) @(posedge pclk);
        wrap_up();
    end
endmodule
